/* File: core/ipeg_consts.svh */
// offsets, field positions, reset values and counts of the event generator
`ifndef IPEG_CONSTS_SVH
`define IPEG_CONSTS_SVH

// ==========================================================
// register byte offsets
`define IPEG_OFS_NMI0      8'h00
`define IPEG_OFS_NMI1      8'h04
`define IPEG_OFS_RAISE0    8'h08
`define IPEG_OFS_RAISE1    8'h0c
`define IPEG_OFS_ACK0      8'h10
`define IPEG_OFS_ACK1      8'h14
`define IPEG_OFS_IRQ_STAT  8'h18
`define IPEG_OFS_IRQ_MASK  8'h1c

// ==========================================================
// field positions and reset values
`define IPEG_FIRE_BIT      0
`define IPEG_SRC_LSB       4
`define IPEG_SRC_MSB       31
`define IPEG_NUM_SRC       28
`define IPEG_NUM_CORES     2
`define IPEG_SRC_RESET     28'h0000000
`define IPEG_EVT_RESET     4'h0
`define IPEG_ADDR_W        8

`endif

/* File: core/ipeg_pkg.sv */
// types shared by the event generator files
package ipeg_pkg;

  // ==========================================================
  // decoded register write
  typedef struct packed {
    logic [1:0] nmi;
    logic [1:0] raise;
    logic [1:0] ack;
    logic       stat;
    logic       mask;
  } ipeg_sel_t;

  // ==========================================================
  // one pulse per core and kind
  typedef struct packed {
    logic [1:0] nmi;
    logic [1:0] irq;
  } ipeg_evt_t;

  typedef enum logic [1:0] {
    IPEG_IDLE,
    IPEG_DONE
  } ipeg_bus_state_t;

endpackage : ipeg_pkg

/* File: core/ipeg_src_flags.sv */
// source flags of one core with set and clear through two views
`timescale 1ns/100ps
`include "ipeg_consts.svh"

module ipeg_src_flags
  import ipeg_pkg::*;
#(
  parameter int NUM_SRC = `IPEG_NUM_SRC
) (
  input  wire logic               sys_clk_i,
  input  wire logic               srst_i,
  input  wire logic               set_en_i,
  input  wire logic               clr_en_i,
  input  wire logic [NUM_SRC-1:0] data_i,
  output logic      [NUM_SRC-1:0] flags_o
);

  // ==========================================================
  // flag storage
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flags_o <= NUM_SRC'(`IPEG_SRC_RESET);
    end else begin
      // clear applied first so a set in the same cycle wins
      flags_o <= (flags_o & ~(clr_en_i ? data_i : '0))
               | (set_en_i ? data_i : '0);
    end
  end

endmodule : ipeg_src_flags

/* File: core/ipeg_evt_status.sv */
// sticky event status, mask and interrupt output
`timescale 1ns/100ps
`include "ipeg_consts.svh"

module ipeg_evt_status
  import ipeg_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic [3:0] evt_i,
  input  wire logic       clr_en_i,
  input  wire logic       mask_en_i,
  input  wire logic [3:0] wdata_i,
  output logic      [3:0] status_o,
  output logic      [3:0] mask_o,
  output logic            irq_o
);

  // ==========================================================
  // status: write one clears, a new event wins
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      status_o <= `IPEG_EVT_RESET;
    end else begin
      status_o <= (status_o & ~(clr_en_i ? wdata_i : 4'h0)) | evt_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mask_o <= `IPEG_EVT_RESET;
    end else if (mask_en_i) begin
      mask_o <= wdata_i;
    end
  end

  assign irq_o = |(status_o & mask_o);

endmodule : ipeg_evt_status

/* File: core/ipeg_core.sv */
// interprocessor event generator with avalon-mm register slave
`timescale 1ns/100ps
`include "ipeg_consts.svh"

// ==========================================================
// Overview of operation
// - writing one to bit 0 of nmi register x pulses nmi to core x
// - writing zero there does nothing; reads return zero, no side effect
// - two nmi, two raise and two acknowledge registers, one per core
// - writing one to raise bit 0 pulses core irq; bit reads zero
// - ones in raise bits 31..4 set the shared source flags
// - ones in acknowledge bits 31..4 clear the shared source flags
// - both views read the same single flag per source
// - each core holds 28 independent source flags at bits 31..4
// - flags reset to zero; reserved low bits read zero
// - any bus master may write these registers
module ipeg_core
  import ipeg_pkg::*;
#(
  parameter int NUM_SRC = `IPEG_NUM_SRC
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    srst_i,
  input  wire logic [`IPEG_ADDR_W-1:0] avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  output logic      [1:0]              nmi_pulse_o,
  output logic      [1:0]              core_irq_pulse_o,
  output logic                         irq_o
);

  // ==========================================================
  // declarations
  ipeg_bus_state_t        state;
  ipeg_bus_state_t        next_state;
  ipeg_sel_t              wsel;
  ipeg_evt_t              evt;
  // transfer qualifiers and strobes
  logic                   req_any;
  logic                   data_phase;
  logic                   wr_acc;
  logic                   rd_load;
  logic                   full_word;
  logic                   fire_bit;
  logic                   stat_clr;
  logic                   mask_wr;
  logic [1:0]             nmi_fire;
  logic [1:0]             irq_fire;
  logic [1:0]             set_sel;
  logic [1:0]             clr_sel;
  // pulse and flag state
  logic [1:0]             nmi_q;
  logic [1:0]             irq_q;
  logic [NUM_SRC-1:0]     src_data;
  logic [NUM_SRC-1:0]     flags [2];
  logic [3:0]             evt_vec;
  logic [3:0]             low_wdata;
  logic [3:0]             status;
  logic [3:0]             mask;
  // read path
  logic                   src_rd [2];
  logic [31:0]            src_words [2];
  logic [31:0]            stat_word;
  logic [31:0]            mask_word;
  logic [31:0]            next_rdata;

  function automatic ipeg_sel_t decode(input logic [`IPEG_ADDR_W-1:0] a);
    ipeg_sel_t s;
    s = '0;
    if (a == `IPEG_OFS_NMI0) begin
      s.nmi[0] = 1'b1;
    end else if (a == `IPEG_OFS_NMI1) begin
      s.nmi[1] = 1'b1;
    end else if (a == `IPEG_OFS_RAISE0) begin
      s.raise[0] = 1'b1;
    end else if (a == `IPEG_OFS_RAISE1) begin
      s.raise[1] = 1'b1;
    end else if (a == `IPEG_OFS_ACK0) begin
      s.ack[0] = 1'b1;
    end else if (a == `IPEG_OFS_ACK1) begin
      s.ack[1] = 1'b1;
    end else if (a == `IPEG_OFS_IRQ_STAT) begin
      s.stat = 1'b1;
    end else if (a == `IPEG_OFS_IRQ_MASK) begin
      s.mask = 1'b1;
    end
    return s;
  endfunction : decode

  // ==========================================================
  // source view decode; raise and acknowledge share one flag set
  function automatic logic is_src_view(input logic [`IPEG_ADDR_W-1:0] a,
                                       input int                      core);
    logic hit;
    hit = 1'b0;
    if (core == 0) begin
      hit = (a == `IPEG_OFS_RAISE0) || (a == `IPEG_OFS_ACK0);
    end else if (core == 1) begin
      hit = (a == `IPEG_OFS_RAISE1) || (a == `IPEG_OFS_ACK1);
    end
    return hit;
  endfunction : is_src_view

  // ==========================================================
  // read word of one source view; low four bits are never stored
  // view width follows NUM_SRC; only 28 fills the word exactly
  function automatic logic [31:0] src_word(input logic [NUM_SRC-1:0] f);
    logic [31:0] wd;
    wd = 32'h00000000;
    wd[`IPEG_SRC_MSB:`IPEG_SRC_LSB] = f;
    return wd;
  endfunction : src_word

  // ==========================================================
  // offsets that answer with a register; all others read zero
  function automatic logic is_mapped(input logic [`IPEG_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a <= `IPEG_OFS_IRQ_MASK && a[1:0] == 2'h0) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_mapped

  // ==========================================================
  // bus handshake: one wait cycle, then accept
  always_comb begin
    next_state = state;
    case (state)
      IPEG_IDLE: begin
        if (req_any) begin
          next_state = IPEG_DONE;
        end
      end
      default: begin
        // the data phase lasts one cycle, so held requests alternate
        next_state = IPEG_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= IPEG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // transfer qualifiers
  assign req_any           = avs_read_i || avs_write_i;
  assign data_phase        = (state == IPEG_DONE);
  assign avs_waitrequest_o = req_any && !data_phase;
  // any master's write is accepted alike
  assign wr_acc            = avs_write_i && data_phase;
  // read word is captured in the wait cycle so it stands when wait drops
  assign rd_load           = avs_read_i && !data_phase;
  // partial word writes are ignored; fire bits live in lane 0 only
  assign full_word         = &avs_byteenable_i;
  assign fire_bit          = avs_writedata_i[`IPEG_FIRE_BIT];
  assign src_data          = avs_writedata_i[`IPEG_SRC_MSB:`IPEG_SRC_LSB];
  assign low_wdata         = avs_writedata_i[3:0];

  // unmapped offsets never raise a strobe
  always_comb begin
    wsel = (wr_acc && full_word && is_mapped(avs_address_i)) ? decode(avs_address_i) : '0;
  end

  // ==========================================================
  // named strobes of the decoded write
  // a zero in the fire bit leaves both pulse kinds low
  assign nmi_fire = wsel.nmi & {2{fire_bit}};
  assign irq_fire = wsel.raise & {2{fire_bit}};
  assign set_sel  = wsel.raise;
  assign clr_sel  = wsel.ack;
  assign stat_clr = wsel.stat;
  assign mask_wr  = wsel.mask;

  // ==========================================================
  // nmi pulses, one cycle after acceptance
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      nmi_q <= 2'h0;
    end else begin
      // registered so the pulse never glitches with the bus
      nmi_q <= nmi_fire;
    end
  end

  // ==========================================================
  // core irq pulses, one cycle after acceptance
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_q <= 2'h0;
    end else begin
      irq_q <= irq_fire;
    end
  end

  assign evt              = {nmi_q, irq_q};
  assign nmi_pulse_o      = evt.nmi;
  assign core_irq_pulse_o = evt.irq;

  // ==========================================================
  // status order: nmi core 0, nmi core 1, irq core 0, irq core 1
  assign evt_vec = {evt.irq[1], evt.irq[0], evt.nmi[1], evt.nmi[0]};

  // ==========================================================
  // per-core source flags, meaning left to software
  genvar c;
  generate
    for (c = 0; c < `IPEG_NUM_CORES; c++) begin : g_core
      ipeg_src_flags #(.NUM_SRC(NUM_SRC)) u_flags (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .set_en_i  (set_sel[c]),
        .clr_en_i  (clr_sel[c]),
        .data_i    (src_data),
        .flags_o   (flags[c])
      );
    end
  endgenerate

  // ==========================================================
  // which core's source view a read addresses
  // one decode per core keeps the two views aligned
  genvar v;
  generate
    for (v = 0; v < `IPEG_NUM_CORES; v++) begin : g_view
      assign src_rd[v] = is_src_view(avs_address_i, v);
    end
  endgenerate

  // ==========================================================
  // read words of the two source views
  genvar k;
  generate
    for (k = 0; k < `IPEG_NUM_CORES; k++) begin : g_word
      assign src_words[k] = src_word(flags[k]);
    end
  endgenerate

  // ==========================================================
  // read words of event status and mask; upper bits unused
  assign stat_word = {28'h0000000, status};
  assign mask_word = {28'h0000000, mask};

  // ==========================================================
  // event status and interrupt
  // status events win over a clear written in the same cycle
  ipeg_evt_status u_status (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .evt_i     (evt_vec),
    .clr_en_i  (stat_clr),
    .mask_en_i (mask_wr),
    .wdata_i   (low_wdata),
    .status_o  (status),
    .mask_o    (mask),
    .irq_o     (irq_o)
  );

  // ==========================================================
  // read mux; fire bits and reserved bits read zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (avs_address_i == `IPEG_OFS_NMI0) begin
      // a fire bit keeps no state, so the whole word reads zero
      next_rdata = 32'h00000000;
    end else if (avs_address_i == `IPEG_OFS_NMI1) begin
      next_rdata = 32'h00000000;
    end else if (src_rd[0]) begin
      next_rdata = src_words[0];
    end else if (src_rd[1]) begin
      next_rdata = src_words[1];
    end else if (avs_address_i == `IPEG_OFS_IRQ_STAT) begin
      next_rdata = stat_word;
    end else if (avs_address_i == `IPEG_OFS_IRQ_MASK) begin
      next_rdata = mask_word;
    end else begin
      // unmapped offsets read zero as well
      next_rdata = 32'h00000000;
    end
  end

  // ==========================================================
  // read data register; stands until the next read
  // loaded in the wait cycle, so it stands at the accepting edge
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (rd_load) begin
      avs_readdata_o <= next_rdata;
    end
  end

endmodule : ipeg_core

/* File: tb/ipeg_core_monitor.sv */
// assertion checker for the event generator ports
`timescale 1ns/100ps

module ipeg_core_monitor
  import ipeg_pkg::*;
#(
  parameter int NUM_SRC = 28
) (
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  nmi_pulse_o,
  input wire logic [1:0]  core_irq_pulse_o,
  input wire logic        irq_o
);
  // ==========================================================
  // accepted transfers; partial byte enables never take effect
  wire logic       wa = avs_write_i & ~avs_waitrequest_o & (&avs_byteenable_i);
  wire logic       ra = avs_read_i & ~avs_waitrequest_o;
  wire logic [7:0] a  = avs_address_i;
  wire logic       f  = avs_writedata_i[0];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  AST_NMI0: assert property (wa && a == 8'h00 && f |=> nmi_pulse_o[0] ##1 !nmi_pulse_o[0])
    else $error("nmi pulse of core 0 wrong");
  AST_NMI1: assert property (wa && a == 8'h04 && f |=> nmi_pulse_o == 2'h2 ##1 !nmi_pulse_o[1])
    else $error("nmi pulse of core 1 wrong");
  AST_IRQ0: assert property (wa && a == 8'h08 && f |=> core_irq_pulse_o == 2'h1 ##1 !core_irq_pulse_o[0])
    else $error("irq pulse of core 0 wrong");
  AST_IRQ1: assert property (wa && a == 8'h0c && f |=> core_irq_pulse_o[1] ##1 !core_irq_pulse_o[1])
    else $error("irq pulse of core 1 wrong");
  AST_CAUSE: assert property (|nmi_pulse_o |-> $past(wa && a[7:3] == 5'h00 && f))
    else $error("nmi pulse without a firing write");
  AST_WAIT: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("waitrequest sequence wrong");
  AST_RDZ: assert property (ra && a[7:3] == 5'h00 |-> avs_readdata_o == 32'h0)
    else $error("nmi register read not zero");
  AST_RESV: assert property (ra && a >= 8'h08 && a <= 8'h14 |-> avs_readdata_o[3:0] == 4'h0)
    else $error("low bits of source register not zero");
endmodule : ipeg_core_monitor

/* File: tb/ipeg_cores_model.sv */
// model of the two receiving cores, counting pulses
`timescale 1ns/100ps

module ipeg_cores_model
  import ipeg_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic            srst_i,
  input  wire ipeg_evt_t       evt_i,
  output logic      [3:0][7:0] cnt_o
);
  // ==========================================================
  // source bits carry no meaning here, only pulses are counted
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (srst_i) cnt_o[i] <= 8'h00;
      else if (evt_i[i]) cnt_o[i] <= cnt_o[i] + 8'h01;
    end
  end
endmodule : ipeg_cores_model

/* File: tb/testbench.sv */
// self-checking testbench of the event generator
`timescale 1ns/100ps

module testbench
  import ipeg_pkg::*;
;
  logic sys_clk_i, srst_i, rd, wr, wreq, irq;
  logic [7:0]      addr;
  logic [31:0]     wd, rdata, rv;
  logic [3:0]      be;
  logic [1:0]      nmi_p, irq_p;
  logic [3:0][7:0] cnt;
  int              num_errors, comparisons, cyc;

  ipeg_core ipeg_core_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .nmi_pulse_o(nmi_p),
    .core_irq_pulse_o(irq_p), .irq_o(irq));
  ipeg_cores_model ipeg_cores_model_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .evt_i({nmi_p, irq_p}), .cnt_o(cnt));

  // ==========================================================
  // bus access and comparison
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge sys_clk_i);
    while (wreq) @(posedge sys_clk_i);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask : rdc
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // hang guard, generous against some 115 cycles of traffic
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done;
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    {srst_i, rd, wr, addr, wd, be} = {3'b100, 8'h00, 32'h0, 4'hf};
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 36; a += 4) rdc(a[7:0], 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h00, 32'hfffffffe);
    rdc(8'h00, 32'h0);
    chk({24'h0, cnt[2]}, 32'h1);
    chk({24'h0, cnt[3]}, 32'h1);
    bus(1'b1, 8'h08, 32'hfffffff1);
    rdc(8'h08, 32'hfffffff0);
    rdc(8'h10, 32'hfffffff0);
    rdc(8'h0c, 32'h0);
    chk({16'h0, cnt[1:0]}, 32'h0001);
    bus(1'b1, 8'h14, 32'hffffffff);
    bus(1'b1, 8'h10, 32'h0f0000f0);
    rdc(8'h08, 32'hf0ffff00);
    bus(1'b1, 8'h0c, 32'h00000012);
    rdc(8'h14, 32'h00000010);
    chk({24'h0, cnt[1]}, 32'h0);
    bus(1'b1, 8'h0c, 32'h00000001);
    rdc(8'h0c, 32'h00000010);
    chk({24'h0, cnt[1]}, 32'h1);
    rdc(8'h18, 32'hf);
    bus(1'b1, 8'h1c, 32'h4);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h18, 32'h4);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h18, 32'hb);
    bus(1'b1, 8'h20, 32'hffffffff);
    rdc(8'h20, 32'h0);
    be <= 4'h1;
    bus(1'b1, 8'h08, 32'h00000011);
    be <= 4'hf;
    rdc(8'h08, 32'hf0ffff00);
    chk({24'h0, cnt[0]}, 32'h1);
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rdc(8'h08, 32'h0);
    rdc(8'h18, 32'h0);
    test_done;
  end
endmodule : testbench

bind ipeg_core ipeg_core_monitor #(.NUM_SRC(NUM_SRC)) ipeg_core_monitor_inst (.sys_clk_i,
  .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .nmi_pulse_o, .core_irq_pulse_o, .irq_o);
